// ### rtl/twi_status_irq.sv
// Overview of operation
// R01: alert seen on the bus sets alert flag until software clears it.
// R02: released SDA read low at SCL rise sets arbitration-lost flag.
// R03: slave NAK in data phase sets data-NAK flag.
// R04: no ACK in address phase sets address-NAK flag.
// R05: ones written to flag-clear clear the matching sticky flags.
// R06: idle flag high exactly when nothing executes and nothing is pending.
// R07: command-done set only on success with STOP sent.
// R08: failed command never sets command-done.
// R09: command-ready high while either command slot can accept a command.
// R10: tx-ready high while holding register has room and transfer runs.
// R11: rx-ready high while a received byte waits.
// R12: ones written to enable register set mask bits; only bits 0-4 and 8-13 can be set, so stop-accepted can never be enabled.
// R13: ones written to disable register clear mask bits.
// R14: mask register reads enabled sources, zero after reset.
// R15: zero bits in enable, disable, clear writes change nothing.
// R16: read-only version word with version and variant, no effect.
// R17: accepted stop request sets stop-accepted flag.
// R18: PEC mismatch in SMBus mode sets PEC-error flag.
// R19: SMBus timeout sets timeout flag.
// R20: status word shows master-enabled as a read-only bit.
// R21: interrupt high when any flag is set with its mask bit.
// R22: parameter word reads zero; writes to read-only words ignored.
`timescale 1ns/100ps
`default_nettype none
module twi_status_irq
  import twi_status_pkg::*;
#(
  parameter logic [11:0] VERSION_NUM = 12'h001, // value arbitrary
  parameter logic [3:0]  VARIANT_NUM = 4'h0     // value arbitrary
) (
  input  wire logic        pclk,      // bus clock, 125 MHz
  input  wire logic        presetn,   // async reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb direction
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error, unmapped address
  input  wire pin_bits_t   pins,      // scl, sda, alert_n from pads
  input  wire engine_evt_t ev,        // one-cycle events from engine
  input  wire engine_lvl_t lvl,       // levels from engine
  output logic             irq        // interrupt request
);

  // ----------------------------------------------------------------
  // pins and flags
  // ----------------------------------------------------------------
  core_state_t           st;
  core_state_t           ns;
  pin_bits_t             pins_s;
  logic [NUM_STICKY-1:0] sticky_q;
  logic [NUM_STICKY-1:0] sticky_set;
  logic [NUM_STICKY-1:0] sticky_clr;
  logic                  scl_rise;
  logic                  access;
  logic                  commit;
  logic                  mapped;
  logic                  wr_commit;
  logic [31:0]           level_bits;
  logic [31:0]           flag_bits;

  pin_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (pins),
    .pins_s  (pins_s)
  );

  sticky_flags u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (sticky_set),
    .clr     (sticky_clr),
    .flags   (sticky_q)
  );

  assign scl_rise = pins_s.scl & ~st.scl_q;
  assign access   = psel & penable;
  // pready is high in the second access cycle; that edge commits
  assign commit    = access & st.ready;
  assign wr_commit = commit & pwrite & ~st.err;

  always_comb begin
    case (paddr)
      OFS_STATUS, OFS_IRQ_SET, OFS_IRQ_CLR, OFS_IRQ_ST,
      OFS_FLAGCLR, OFS_PARAM, OFS_VERSION: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    sticky_set          = '0;
    sticky_set[SF_ALERT] = ~pins_s.alert_n; // R01
    // only while we release sda for our own bit; ack slots excluded
    sticky_set[SF_ARB]  = scl_rise & lvl.drive_data_bit
                          & ~lvl.sda_drive_low & ~pins_s.sda; // R02
    sticky_set[SF_DATA_NAK] = ev.data_nak; // R03
    sticky_set[SF_ADDR_NAK] = ev.addr_nak; // R04
    sticky_set[SF_DONE] = ev.cmd_finished & ev.stop_sent
                          & ~ev.cmd_failed; // R07 R08
    sticky_set[SF_STOP] = ev.stop_accept; // R17
    sticky_set[SF_PEC]  = ev.pec_mismatch & lvl.smbus_mode; // R18
    sticky_set[SF_TIMEOUT] = ev.timeout; // R19
  end

  always_comb begin
    sticky_clr = '0;
    if (wr_commit && paddr == OFS_FLAGCLR) begin
      sticky_clr[SF_DONE]  = pwdata[BIT_CMD_DONE]; // R05 R15
      sticky_clr[SF_ADDR_NAK] = pwdata[BIT_ADDR_NAK]; // R05
      sticky_clr[SF_DATA_NAK] = pwdata[BIT_DATA_NAK]; // R05
      sticky_clr[SF_ARB]   = pwdata[BIT_ARB_LOST]; // R05
      sticky_clr[SF_ALERT] = pwdata[BIT_ALERT]; // R05
      sticky_clr[SF_TIMEOUT] = pwdata[BIT_TIMEOUT]; // R05
      sticky_clr[SF_PEC]   = pwdata[BIT_PEC_ERR]; // R05
      sticky_clr[SF_STOP]  = pwdata[BIT_STOP_ACC]; // R05
    end
  end

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  always_comb begin
    level_bits                = '0;
    level_bits[BIT_RX_READY]  = lvl.rx_hold_valid; // R11
    level_bits[BIT_TX_READY]  = ~lvl.tx_hold_full & ~lvl.tx_stopped; // R10
    level_bits[BIT_CMD_READY] = ~lvl.cur_cmd_valid | ~lvl.next_cmd_valid; // R09
    level_bits[BIT_IDLE]      = ~lvl.cmd_busy & ~lvl.next_cmd_valid
                                & ~lvl.cur_cmd_valid; // R06
    level_bits[BIT_MASTER_EN] = lvl.master_enabled; // R20
    flag_bits                 = '0;
    flag_bits[BIT_CMD_DONE]   = sticky_q[SF_DONE];
    flag_bits[BIT_ADDR_NAK]   = sticky_q[SF_ADDR_NAK];
    flag_bits[BIT_DATA_NAK]   = sticky_q[SF_DATA_NAK];
    flag_bits[BIT_ARB_LOST]   = sticky_q[SF_ARB];
    flag_bits[BIT_ALERT]      = sticky_q[SF_ALERT];
    flag_bits[BIT_TIMEOUT]    = sticky_q[SF_TIMEOUT];
    flag_bits[BIT_PEC_ERR]    = sticky_q[SF_PEC];
    flag_bits[BIT_STOP_ACC]   = sticky_q[SF_STOP];
  end

  // ----------------------------------------------------------------
  // apb slave and mask
  // ----------------------------------------------------------------
  always_comb begin
    ns        = st;
    ns.scl_q  = pins_s.scl;
    ns.status = level_bits | flag_bits;
    ns.ready  = access & ~st.ready;
    ns.err    = access & ~st.ready & ~mapped;
    if (access && !st.ready) begin
      case (paddr)
        OFS_STATUS:  ns.rdata = st.status;
        OFS_IRQ_ST:  ns.rdata = st.mask; // R14
        OFS_PARAM:   ns.rdata = PARAM_VALUE; // R22
        OFS_VERSION: begin
          ns.rdata = '0;
          ns.rdata[VER_NUM_LSB +: 12] = VERSION_NUM; // R16
          ns.rdata[VARIANT_LSB +: 4]  = VARIANT_NUM; // R16
        end
        default:     ns.rdata = '0;
      endcase
    end
    // writes to status, mask, parameter and version fall through
    if (wr_commit && paddr == OFS_IRQ_SET) begin
      ns.mask = st.mask | (pwdata & MASKABLE_BITS); // R12 R15
    end
    if (wr_commit && paddr == OFS_IRQ_CLR) begin
      ns.mask = st.mask & ~(pwdata & MASKABLE_BITS); // R13 R15
    end
    ns.irq = |(ns.status & ns.mask); // R21
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st       <= '0;
      st.status <= STATUS_RESET;
      st.mask  <= MASK_RESET; // R14
      st.scl_q <= 1'b1;
    end else begin
      st <= ns;
    end
  end

  assign prdata  = st.rdata;
  assign pready  = st.ready;
  assign pslverr = st.err;
  assign irq     = st.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_alert_set; // R01
    !pins_s.alert_n |-> ##2 st.status[BIT_ALERT];
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert flag not set"); // R01

  property p_arb_lost; // R02
    (scl_rise && lvl.drive_data_bit && !lvl.sda_drive_low && !pins_s.sda)
      |-> ##2 st.status[BIT_ARB_LOST];
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss missed"); // R02

  property p_data_nak; // R03
    ev.data_nak |-> ##1 sticky_q[SF_DATA_NAK] ##1 st.status[BIT_DATA_NAK];
  endproperty
  a_data_nak: assert property (p_data_nak) else $error("data nak flag not set"); // R03

  property p_addr_nak; // R04
    ev.addr_nak |-> ##2 st.status[BIT_ADDR_NAK];
  endproperty
  a_addr_nak: assert property (p_addr_nak) else $error("address nak flag not set"); // R04

  property p_clear_done; // R05
    (wr_commit && paddr == OFS_FLAGCLR && pwdata[BIT_CMD_DONE]
      && !sticky_set[SF_DONE]) |-> ##2 !st.status[BIT_CMD_DONE];
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("done flag not cleared"); // R05

  property p_idle; // R06
    presetn |=> st.status[BIT_IDLE] == (!$past(lvl.cmd_busy) && !$past(lvl.next_cmd_valid)
                                        && !$past(lvl.cur_cmd_valid));
  endproperty
  a_idle: assert property (p_idle) else $error("idle flag wrong"); // R06

  property p_done_set; // R07
    (ev.cmd_finished && ev.stop_sent && !ev.cmd_failed)
      |-> ##2 st.status[BIT_CMD_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set"); // R07

  property p_fail_no_done; // R08
    (ev.cmd_failed && !sticky_q[SF_DONE]) |-> ##2 !st.status[BIT_CMD_DONE];
  endproperty
  a_fail_no_done: assert property (p_fail_no_done) else $error("done set on failure"); // R08

  property p_cmd_ready; // R09
    presetn |=> st.status[BIT_CMD_READY]
                == !($past(lvl.cur_cmd_valid) && $past(lvl.next_cmd_valid));
  endproperty
  a_cmd_ready: assert property (p_cmd_ready) else $error("command ready wrong"); // R09

  property p_tx_ready; // R10
    (lvl.tx_hold_full || lvl.tx_stopped) |=> !st.status[BIT_TX_READY];
  endproperty
  a_tx_ready: assert property (p_tx_ready) else $error("tx ready high when blocked"); // R10

  property p_rx_ready; // R11
    presetn |=> st.status[BIT_RX_READY] == $past(lvl.rx_hold_valid);
  endproperty
  a_rx_ready: assert property (p_rx_ready) else $error("rx ready wrong"); // R11

  property p_mask_set; // R12
    (wr_commit && paddr == OFS_IRQ_SET)
      |=> ((st.mask & $past(pwdata) & MASKABLE_BITS) == ($past(pwdata) & MASKABLE_BITS));
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask bits not set"); // R12

  property p_mask_clr; // R13
    (wr_commit && paddr == OFS_IRQ_CLR) |=> ((st.mask & $past(pwdata)) == '0);
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask bits not cleared"); // R13

  property p_mask_hold; // R15
    !(wr_commit && (paddr == OFS_IRQ_SET || paddr == OFS_IRQ_CLR)) |=> $stable(st.mask);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("mask changed without write"); // R15

  property p_irq; // R21
    irq == |(st.status & st.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq does not match flags and mask"); // R21

  property p_param_zero; // R22
    (access && !st.ready && !pwrite && paddr == OFS_PARAM)
      |=> pready && !pslverr && prdata == PARAM_VALUE;
  endproperty
  a_param_zero: assert property (p_param_zero) else $error("parameter word not zero"); // R22

  property p_stop_acc; // R17
    ev.stop_accept |-> ##2 st.status[BIT_STOP_ACC];
  endproperty
  a_stop_acc: assert property (p_stop_acc) else $error("stop flag not set"); // R17

  property p_pec_set; // R18
    (ev.pec_mismatch && lvl.smbus_mode) |-> ##2 st.status[BIT_PEC_ERR];
  endproperty
  a_pec_set: assert property (p_pec_set) else $error("pec flag not set"); // R18

  property p_pec_gate; // R18
    (!sticky_q[SF_PEC] && !(ev.pec_mismatch && lvl.smbus_mode)) |=> !sticky_q[SF_PEC];
  endproperty
  a_pec_gate: assert property (p_pec_gate) else $error("pec flag set outside smbus"); // R18

  property p_timeout; // R19
    ev.timeout |-> ##2 st.status[BIT_TIMEOUT];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag not set"); // R19

  property p_master_en; // R20
    presetn |=> st.status[BIT_MASTER_EN] == $past(lvl.master_enabled);
  endproperty
  a_master_en: assert property (p_master_en) else $error("master enabled bit wrong"); // R20

  property p_tx_ready_set; // R10
    presetn |=> st.status[BIT_TX_READY]
                == (!$past(lvl.tx_hold_full) && !$past(lvl.tx_stopped));
  endproperty
  a_tx_ready_set: assert property (p_tx_ready_set) else $error("tx ready wrong"); // R10

  property p_version; // R16
    (access && !st.ready && !pwrite && paddr == OFS_VERSION)
      |=> prdata[VER_NUM_LSB +: 12] == VERSION_NUM
          && prdata[VARIANT_LSB +: 4] == VARIANT_NUM;
  endproperty
  a_version: assert property (p_version) else $error("version word wrong"); // R16

  property p_mask_read; // R14
    (access && !st.ready && !pwrite && paddr == OFS_IRQ_ST)
      |=> prdata == $past(st.mask);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read wrong"); // R14

  property p_flag_hold; // R15
    (sticky_set == '0 && sticky_clr == '0) |=> $stable(sticky_q);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag changed without cause"); // R15

  property p_clear_any; // R05
    ((sticky_clr & ~sticky_set) != '0)
      |=> ((sticky_q & $past(sticky_clr) & ~$past(sticky_set)) == '0);
  endproperty
  a_clear_any: assert property (p_clear_any) else $error("flag not cleared"); // R05

  property p_unmasked; // R12
    (st.mask & ~MASKABLE_BITS) == '0;
  endproperty
  a_unmasked: assert property (p_unmasked) else $error("mask holds unmaskable bit"); // R12

endmodule
`default_nettype wire

// ### rtl/twi_status_pkg.sv
package twi_status_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_IRQ_SET = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h28;
  localparam logic [7:0] OFS_FLAGCLR = 8'h2c;
  localparam logic [7:0] OFS_PARAM   = 8'h30;
  localparam logic [7:0] OFS_VERSION = 8'h34;

  // ----------------------------------------------------------------
  // status and version word bit positions
  // ----------------------------------------------------------------
  localparam int BIT_RX_READY  = 0;
  localparam int BIT_TX_READY  = 1;
  localparam int BIT_CMD_READY = 2;
  localparam int BIT_CMD_DONE  = 3;
  localparam int BIT_IDLE      = 4;
  localparam int BIT_ADDR_NAK  = 8;
  localparam int BIT_DATA_NAK  = 9;
  localparam int BIT_ARB_LOST  = 10;
  localparam int BIT_ALERT     = 11;
  localparam int BIT_TIMEOUT   = 12;
  localparam int BIT_PEC_ERR   = 13;
  localparam int BIT_STOP_ACC  = 14;
  localparam int BIT_MASTER_EN = 16;
  localparam int VER_NUM_LSB   = 0;
  localparam int VARIANT_LSB   = 16;

  localparam logic [31:0] MASKABLE_BITS = 32'h0000_3f1f;
  localparam logic [31:0] CLEARABLE_BITS = 32'h0000_7f08;
  localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
  localparam logic [31:0] PARAM_VALUE   = 32'h0000_0000;

  // sticky flag slots inside sticky_flags
  localparam int NUM_STICKY = 8;
  localparam int SF_DONE    = 0;
  localparam int SF_ADDR_NAK = 1;
  localparam int SF_DATA_NAK = 2;
  localparam int SF_ARB     = 3;
  localparam int SF_ALERT   = 4;
  localparam int SF_TIMEOUT = 5;
  localparam int SF_PEC     = 6;
  localparam int SF_STOP    = 7;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic stop_accept;
    logic pec_mismatch;
    logic timeout;
    logic addr_nak;
    logic data_nak;
    logic cmd_finished;
    logic cmd_failed;
    logic stop_sent;
  } engine_evt_t;

  typedef struct packed {
    logic cur_cmd_valid;
    logic next_cmd_valid;
    logic cmd_busy;
    logic tx_hold_full;
    logic tx_stopped;
    logic rx_hold_valid;
    logic master_enabled;
    logic smbus_mode;
    logic drive_data_bit;
    logic sda_drive_low;
  } engine_lvl_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic alert_n;
  } pin_bits_t;

  typedef struct packed {
    pin_bits_t meta;
    pin_bits_t sync;
  } sync_state_t;

  typedef struct packed {
    logic [NUM_STICKY-1:0] flags;
  } sticky_state_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq;
    logic        scl_q;
  } core_state_t;

endpackage

// ### rtl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import twi_status_pkg::*;
(
  input  wire logic      pclk,    // bus clock
  input  wire logic      presetn, // async reset, active low
  input  wire pin_bits_t pins,    // raw bus pins
  output var  pin_bits_t pins_s   // pins after two flops
);
  sync_state_t st;
  sync_state_t ns;

  always_comb begin
    ns      = st;
    ns.meta = pins;
    ns.sync = st.meta;
  end

  // idle bus levels are high, so reset to ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '1;
    end else begin
      st <= ns;
    end
  end

  assign pins_s = st.sync;
endmodule
`default_nettype wire

// ### rtl/sticky_flags.sv
`timescale 1ns/100ps
`default_nettype none
module sticky_flags
  import twi_status_pkg::*;
(
  input  wire logic                  pclk,    // bus clock
  input  wire logic                  presetn, // async reset, active low
  input  wire logic [NUM_STICKY-1:0] set,     // hardware event per flag
  input  wire logic [NUM_STICKY-1:0] clr,     // software clear per flag
  output logic      [NUM_STICKY-1:0] flags    // registered flags
);
  sticky_state_t st;
  sticky_state_t ns;

  // set beats clear so an event in the clear cycle survives
  for (genvar i = 0; i < NUM_STICKY; i++) begin : g_flag
    always_comb begin
      ns.flags[i] = set[i] | (st.flags[i] & ~clr[i]); // R05 R15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= ns;
    end
  end

  assign flags = st.flags;
endmodule
`default_nettype wire

// ### sim/bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// far side of the two-wire bus: slaves and a rival master
// ----------------------------------------------------------------
module bus_partner
  import twi_status_pkg::*;
(
  input  wire logic      run,      // clock the bus while high
  input  wire logic      grab_sda, // rival master pulls sda low
  input  wire logic      alert,    // slave raises its alert line
  output var  pin_bits_t pins      // pad levels seen by the block
);
  logic scl;

  // odd start offset keeps scl edges away from pclk edges
  initial begin
    scl = 1'b1;
    #3;
    forever begin
      #40;
      scl = run ? ~scl : 1'b1;
    end
  end

  // both lines have pull-ups, so a released line reads high
  always_comb begin
    pins.scl     = scl;
    pins.sda     = !grab_sda;
    pins.alert_n = !alert;
  end
endmodule
`default_nettype wire

// ### sim/twi_status_irq_bench.sv
`timescale 1ns/100ps
`default_nettype none
module twi_status_irq_bench
  import twi_status_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, irq, pready, pslverr;
  logic        run, grab_sda, alert;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, sticky, mask_m, q, v;
  logic        e;
  engine_evt_t ev;
  engine_lvl_t lvl;
  pin_bits_t   pins;
  integer      seed, fail_count, check_count;

  twi_status_irq #(.VERSION_NUM(12'h5a3), .VARIANT_NUM(4'h9)) twi_status_irq_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .ev(ev), .lvl(lvl), .irq(irq));
  bus_partner bus_partner_inst (.run(run), .grab_sda(grab_sda), .alert(alert), .pins(pins));

  always #4 pclk = ~pclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one idle edge first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
    chk({31'h0, e}, 32'h0);
  endtask

  function automatic logic [31:0] lvl_bits(input engine_lvl_t l);
    logic [31:0] b;
    b = '0;
    b[BIT_RX_READY]  = l.rx_hold_valid;
    b[BIT_TX_READY]  = !l.tx_hold_full && !l.tx_stopped;
    b[BIT_CMD_READY] = !l.cur_cmd_valid || !l.next_cmd_valid;
    b[BIT_IDLE]      = !l.cur_cmd_valid && !l.next_cmd_valid && !l.cmd_busy;
    b[BIT_MASTER_EN] = l.master_enabled;
    return b;
  endfunction

  // status read plus the irq it implies through the mask
  task automatic chk_state();
    rd(OFS_STATUS, sticky | lvl_bits(lvl));
    chk({31'h0, irq}, {31'h0, |((sticky | lvl_bits(lvl)) & mask_m)});
  endtask

  task automatic clear_flags(input logic [31:0] c);
    apb(1'b1, OFS_FLAGCLR, c);
    sticky = sticky & ~(c & CLEARABLE_BITS);
    chk_state();
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    ev = '0; lvl = '0; run = 0; grab_sda = 0; alert = 0;
    seed = 32'he014; fail_count = 0; check_count = 0; sticky = '0; mask_m = MASK_RESET;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);

    rd(OFS_IRQ_ST, MASK_RESET);
    rd(OFS_PARAM, PARAM_VALUE);
    rd(OFS_VERSION, 32'h0009_05a3);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    apb(1'b1, OFS_IRQ_ST, 32'hffff_ffff);
    apb(1'b1, OFS_PARAM, 32'hffff_ffff);
    apb(1'b1, OFS_VERSION, 32'hffff_ffff);
    apb(1'b1, OFS_STATUS, 32'hffff_ffff);
    apb(1'b1, 8'h41, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    rd(OFS_IRQ_ST, MASK_RESET);
    rd(OFS_PARAM, PARAM_VALUE);
    rd(OFS_VERSION, 32'h0009_05a3);
    chk_state();
    $display("test reset_values done");

    for (int i = 0; i < 8; i++) begin
      v = (i == 4) ? 32'h0 : $random(seed);
      if (i[0]) begin
        apb(1'b1, OFS_IRQ_CLR, v);
        mask_m = mask_m & ~v;
      end else begin
        apb(1'b1, OFS_IRQ_SET, v);
        mask_m = mask_m | (v & MASKABLE_BITS);
      end
      rd(OFS_IRQ_ST, mask_m);
      chk_state();
    end
    $display("test mask done");

    for (int i = 0; i < 24; i++) begin
      v = $random(seed);
      @(posedge pclk);
      lvl <= engine_lvl_t'(v[9:0]);
      ev <= engine_evt_t'(v[17:10]);
      @(posedge pclk);
      ev <= '0;
      if (v[17]) sticky[BIT_STOP_ACC] = 1'b1;
      if (v[16] && v[2]) sticky[BIT_PEC_ERR] = 1'b1;
      if (v[15]) sticky[BIT_TIMEOUT] = 1'b1;
      if (v[14]) sticky[BIT_ADDR_NAK] = 1'b1;
      if (v[13]) sticky[BIT_DATA_NAK] = 1'b1;
      if (v[12] && v[10] && !v[11]) sticky[BIT_CMD_DONE] = 1'b1;
      repeat (3) @(posedge pclk);
      chk_state();
      clear_flags($random(seed));
    end
    $display("test events done");

    @(posedge pclk);
    lvl <= engine_lvl_t'(10'h002);
    run <= 1'b1;
    repeat (40) @(posedge pclk);
    chk_state();
    grab_sda <= 1'b1;
    repeat (40) @(posedge pclk);
    run <= 1'b0;
    grab_sda <= 1'b0;
    sticky[BIT_ARB_LOST] = 1'b1;
    repeat (10) @(posedge pclk);
    chk_state();
    alert <= 1'b1;
    repeat (8) @(posedge pclk);
    alert <= 1'b0;
    sticky[BIT_ALERT] = 1'b1;
    repeat (8) @(posedge pclk);
    chk_state();
    clear_flags(32'hffff_ffff);
    $display("test bus_pins done");
    report_and_stop();
  end

  // whole run is well under a thousand cycles; this limit only trips on a hang
  initial begin
    #200000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
